// ---- liu_alarm_pkg.sv ----
// Operation
// - Occurring or ongoing events set their status bit to one.
// - Latched bit stays set until read; read clears; sets again only on new event.
// - Latched all-ones and carrier-loss bits stay set after read while alarm persists.
// - Status write: ones take latest information, zeros hold previous value.
// - Only status bits drive the active-low interrupt, each individually maskable.
// - Interrupt mask at 07H, status layout, zero masks and one enables.
// - All-ones, carrier-loss, clock-loss interrupt on any change; released when read.
// - Other bits interrupt when set; released after read if nothing else pending.
// - E1 all-ones sets below two zeros per 512 bits, clears above two.
// - T1 all-ones sets at five or fewer zeros per 3ms, clears at six.
// - E1 carrier loss after 255 or 2048 zeros; clears on 32 ones in 255 bits.
// - T1 carrier loss after 192 or 1544 zeros; clears on 14 ones in 112 bits.
// - Status at 06H: loop up, loop down, clock loss, ones, carrier, limit, open, pattern.
// - Loop-up and loop-down bits set while programmed loop code is received.
// - Clock-loss bit and pin assert after 5us without transmit clock transition.
// - Current-limit bit asserts whenever limiter activates, enabled or not.
// - Control six bit 3 routes recovered clock and data around jitter attenuator.
// - Control six bits 2 to 0 select the error count source.
`default_nettype none
package liu_alarm_pkg;
    // =========================================
    // Register map
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    localparam logic [7:0] ADDR_MASK   = 8'h07;
    localparam logic [7:0] ADDR_CTRL6  = 8'h0C;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [7:0] CTRL6_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    // =========================================
    // Status fields
    localparam int BIT_LOOP_UP = 7;
    localparam int BIT_LOOP_DOWN = 6;
    localparam int BIT_CLK_LOST = 5;
    localparam int BIT_UA1 = 4;
    localparam int BIT_CARRIER = 3;
    localparam int BIT_PRBS = 0;
    localparam int CTRL6_BYPASS_BIT = 3;
    localparam logic [7:0] LATCHED_BITS = 8'hD8;
    localparam logic [7:0] LEVEL_LATCH  = 8'h18;
    localparam logic [7:0] EDGE_LATCH   = 8'hC0;
    localparam logic [7:0] CHANGE_IRQ   = 8'h38;
    // =========================================
    // Alarm criteria
    localparam logic [9:0]  E1_UA1_WIN   = 10'h200;
    localparam logic [3:0]  E1_UA1_SET   = 4'h1;
    localparam logic [3:0]  E1_UA1_CLR   = 4'h3;
    localparam logic [3:0]  T1_UA1_SET   = 4'h5;
    localparam logic [3:0]  T1_UA1_CLR   = 4'h6;
    localparam logic [11:0] E1_LOSS_ZEROS = 12'h0FF;
    localparam logic [11:0] E1_LOSS_LONG  = 12'h800;
    localparam logic [11:0] T1_LOSS_ZEROS = 12'h0C0;
    localparam logic [11:0] T1_LOSS_LONG  = 12'h608;
    localparam logic [7:0]  E1_LOSS_WIN   = 8'hFF;
    localparam logic [7:0]  T1_LOSS_WIN   = 8'h70;
    localparam logic [5:0]  E1_LOSS_ONES  = 6'h20;
    localparam logic [5:0]  T1_LOSS_ONES  = 6'h0E;
    // =========================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_LOST_NS      = 5000;
    localparam int CLK_LOST_CYC_INT = (CLK_LOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] CLK_LOST_CYC = 10'(CLK_LOST_CYC_INT);
    localparam int T1_WIN_NS     = 3000000;
    localparam int T1_WIN_CYC    = T1_WIN_NS / CLK_PERIOD_NS;
    // =========================================
    // Control six layout
    typedef struct packed {
        logic [3:0] loop_ctrl;
        logic       recovered_clock_attenuator_bypass;
        logic [2:0] error_count_select;
    } ctrl6_t;
endpackage
`default_nettype wire

// ---- liu_alarm_status_interrupt.sv ----
`default_nettype none
module liu_alarm_status_interrupt
    import liu_alarm_pkg::*;
#(
    parameter int T1_WIN = T1_WIN_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            int_n_o,
    input  wire logic       e1_mode_i,
    input  wire logic       long_zero_count_select_i,
    input  wire logic       rx_bit_en_i,
    input  wire logic       receive_line_pos_i,
    input  wire logic       receive_line_neg_i,
    input  wire logic       transmit_clock_in_i,
    input  wire logic       loop_up_match_i,
    input  wire logic       loop_down_match_i,
    input  wire logic       current_limit_hit_i,
    input  wire logic       transmit_open_circuit_i,
    input  wire logic       pattern_detect_i,
    output logic            transmit_clock_lost_o,
    output logic            recovered_clock_attenuator_bypass_o,
    output logic      [2:0] error_count_select_o
);
    // Window counter must also span the 512-bit E1 window
    localparam int UW = $clog2(((T1_WIN > 512) ? T1_WIN : 512) + 1);

    // =========================================
    // Line detectors
    logic          rx_one;
    logic          transmit_clock_in_prev_reg, transmit_clock_in_prev_next;
    logic [9:0]    silent_cnt_reg, silent_cnt_next;
    logic          clk_lost_reg, clk_lost_next;
    logic [11:0]   zrun_reg, zrun_next;
    logic          loss_reg, loss_next;
    logic          rwin_reg, rwin_next;
    logic [7:0]    rcnt_reg, rcnt_next;
    logic [5:0]    rones_reg, rones_next;
    logic [UW-1:0] uwin_reg, uwin_next;
    logic [3:0]    uzero_reg, uzero_next;
    logic          ua1_reg, ua1_next;
    logic [11:0]   zthr;
    logic [3:0]    zcnt;
    logic          wend;

    assign rx_one = receive_line_pos_i | receive_line_neg_i;

    always_comb begin
        transmit_clock_in_prev_next = transmit_clock_in_i;
        silent_cnt_next = silent_cnt_reg;
        clk_lost_next   = clk_lost_reg;
        zrun_next       = zrun_reg;
        loss_next       = loss_reg;
        rwin_next      = rwin_reg;
        rcnt_next      = rcnt_reg;
        rones_next     = rones_reg;
        uwin_next      = uwin_reg;
        uzero_next     = uzero_reg;
        ua1_next       = ua1_reg;
        if (e1_mode_i) begin
            zthr = long_zero_count_select_i ? E1_LOSS_LONG : E1_LOSS_ZEROS;
        end else begin
            zthr = long_zero_count_select_i ? T1_LOSS_LONG : T1_LOSS_ZEROS;
        end
        // Any edge restarts the silence count
        if (transmit_clock_in_i != transmit_clock_in_prev_reg) begin
            silent_cnt_next = 10'h000;
            clk_lost_next   = 1'b0;
        end else if (silent_cnt_reg >= CLK_LOST_CYC - 10'h001) begin
            clk_lost_next = 1'b1;
        end else begin
            silent_cnt_next = silent_cnt_reg + 10'h001;
        end
        zcnt = uzero_reg;
        if (rx_bit_en_i && !rx_one && uzero_reg != 4'hF) begin
            zcnt = uzero_reg + 4'h1;
        end
        // E1 windows count bits, T1 windows count time
        if (e1_mode_i) begin
            wend = rx_bit_en_i && (uwin_reg == UW'(E1_UA1_WIN - 10'h001));
        end else begin
            wend = (uwin_reg >= UW'(T1_WIN - 1));
        end
        if (wend) begin
            uwin_next  = '0;
            uzero_next = 4'h0;
            if (e1_mode_i) begin
                if (zcnt <= E1_UA1_SET) ua1_next = 1'b1;
                if (zcnt >= E1_UA1_CLR) ua1_next = 1'b0;
            end else begin
                if (zcnt <= T1_UA1_SET) ua1_next = 1'b1;
                if (zcnt >= T1_UA1_CLR) ua1_next = 1'b0;
            end
        end else begin
            uzero_next = zcnt;
            if (!e1_mode_i || rx_bit_en_i) uwin_next = uwin_reg + UW'(1);
        end
        if (rx_bit_en_i) begin
            if (rx_one) begin
                zrun_next = 12'h000;
            end else if (zrun_reg < zthr) begin
                zrun_next = zrun_reg + 12'h001;
            end
            if (!rx_one && zrun_reg == zthr - 12'h001) begin
                loss_next = 1'b1;
            end
            // Clear window opens on the first one seen during loss
            if (!loss_reg) begin
                rwin_next = 1'b0;
            end else if (!rwin_reg) begin
                if (rx_one) begin
                    rwin_next  = 1'b1;
                    rcnt_next  = 8'h01;
                    rones_next = 6'h01;
                end
            end else begin
                rcnt_next = rcnt_reg + 8'h01;
                if (rx_one && rones_reg != 6'h3F) rones_next = rones_reg + 6'h01;
                if (rcnt_next == (e1_mode_i ? E1_LOSS_WIN : T1_LOSS_WIN)) begin
                    rwin_next = 1'b0;
                    if (rones_next >= (e1_mode_i ? E1_LOSS_ONES : T1_LOSS_ONES)) begin
                        loss_next = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            transmit_clock_in_prev_reg <= 1'b0;
            silent_cnt_reg <= 10'h000;
            clk_lost_reg   <= 1'b0;
            zrun_reg       <= 12'h000;
            loss_reg       <= 1'b0;
            rwin_reg      <= 1'b0;
            rcnt_reg      <= 8'h00;
            rones_reg     <= 6'h00;
            uwin_reg      <= '0;
            uzero_reg     <= 4'h0;
            ua1_reg       <= 1'b0;
        end else begin
            transmit_clock_in_prev_reg <= transmit_clock_in_prev_next;
            silent_cnt_reg <= silent_cnt_next;
            clk_lost_reg   <= clk_lost_next;
            zrun_reg       <= zrun_next;
            loss_reg       <= loss_next;
            rwin_reg      <= rwin_next;
            rcnt_reg      <= rcnt_next;
            rones_reg     <= rones_next;
            uwin_reg      <= uwin_next;
            uzero_reg     <= uzero_next;
            ua1_reg       <= ua1_next;
        end
    end

    // =========================================
    // Status, mask and control registers
    logic [7:0] live, prev_reg, rise, chg, src, rd_clr;
    logic [7:0] latch_reg, latch_next, status_reg, status_next;
    logic [7:0] pend_reg, pend_next, sel_reg, sel_next;
    logic [7:0] mask_reg, mask_next, rdata_reg, rdata_next;
    ctrl6_t     ctrl6_reg, ctrl6_next;
    logic       int_n_reg, int_n_next;
    logic       rd_st, wr_st;

    assign live = {loop_up_match_i, loop_down_match_i, clk_lost_reg, ua1_reg, loss_reg,
                   current_limit_hit_i, transmit_open_circuit_i, pattern_detect_i};
    assign rise  = live & ~prev_reg;
    assign chg   = live ^ prev_reg;
    assign rd_st = rd_en_i && addr_i == ADDR_STATUS;
    assign wr_st = wr_en_i && addr_i == ADDR_STATUS;

    always_comb begin
        // Read clears only the positions the host just selected
        rd_clr      = rd_st ? sel_reg : 8'h00;
        latch_next  = (latch_reg & ~(rd_clr & LATCHED_BITS))
                    | (rise & EDGE_LATCH) | (live & LEVEL_LATCH);
        src         = (latch_reg & LATCHED_BITS) | (live & ~LATCHED_BITS);
        status_next = status_reg;
        sel_next    = sel_reg;
        mask_next   = mask_reg;
        ctrl6_next  = ctrl6_reg;
        rdata_next  = rdata_reg;
        if (wr_st) begin
            status_next = (wdata_i & src) | (~wdata_i & status_reg);
            sel_next    = wdata_i;
        end else if (rd_st) begin
            status_next = (status_reg & ~(rd_clr & LATCHED_BITS))
                        | (status_reg & rd_clr & live & LEVEL_LATCH);
        end
        if (wr_en_i && addr_i == ADDR_MASK) begin
            mask_next = wdata_i;
        end else if (wr_en_i && addr_i == ADDR_CTRL6) begin
            ctrl6_next = ctrl6_t'(wdata_i);
        end
        if (rd_en_i) begin
            if (addr_i == ADDR_STATUS) begin
                rdata_next = status_reg;
            end else if (addr_i == ADDR_MASK) begin
                rdata_next = mask_reg;
            end else if (addr_i == ADDR_CTRL6) begin
                rdata_next = ctrl6_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
        // New events win over a clear in the same cycle
        pend_next  = (pend_reg & ~rd_clr) | (chg & CHANGE_IRQ)
                   | (rise & ~CHANGE_IRQ);
        int_n_next = ~|(pend_reg & mask_reg);
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prev_reg   <= 8'h00;
            latch_reg  <= STATUS_RST;
            status_reg <= STATUS_RST;
            pend_reg   <= 8'h00;
            sel_reg    <= 8'h00;
            mask_reg   <= MASK_RST;
            ctrl6_reg  <= ctrl6_t'(CTRL6_RST);
            rdata_reg  <= 8'h00;
            int_n_reg  <= 1'b1;
        end else begin
            prev_reg   <= live;
            latch_reg  <= latch_next;
            status_reg <= status_next;
            pend_reg   <= pend_next;
            sel_reg    <= sel_next;
            mask_reg   <= mask_next;
            ctrl6_reg  <= ctrl6_next;
            rdata_reg  <= rdata_next;
            int_n_reg  <= int_n_next;
        end
    end

    assign rdata_o               = rdata_reg;
    assign int_n_o               = int_n_reg;
    assign transmit_clock_lost_o = clk_lost_reg;
    assign recovered_clock_attenuator_bypass_o = ctrl6_reg.recovered_clock_attenuator_bypass;
    assign error_count_select_o  = ctrl6_reg.error_count_select;

    // =========================================
    // Checks
    a_clk_lost_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        transmit_clock_in_i != transmit_clock_in_prev_reg |=> !transmit_clock_lost_o)
        else $error("clock loss held across a clock edge");
    a_change_irq_pend: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ($changed(clk_lost_reg) && !rd_st) |=> pend_reg[BIT_CLK_LOST])
        else $error("clock loss change did not raise interrupt");
    a_int_cause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !int_n_o |-> |($past(pend_reg) & $past(mask_reg)))
        else $error("interrupt low with no unmasked cause");
    a_read_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (rd_st && sel_reg[BIT_LOOP_UP] && !rise[BIT_LOOP_UP]) |=> !latch_reg[BIT_LOOP_UP])
        else $error("loop-up latch survived read");
    a_loss_persists: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (rd_st && loss_reg) |=> latch_reg[BIT_CARRIER])
        else $error("carrier loss cleared while present");
    a_write_holds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_st |=> ((status_reg & ~$past(wdata_i)) == ($past(status_reg) & ~$past(wdata_i))))
        else $error("unselected status bit changed on write");
    a_loss_sets: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (rx_bit_en_i && !rx_one && zrun_reg == zthr - 12'h001) |=> loss_reg)
        else $error("carrier loss missed its zero count");
    a_bypass_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (wr_en_i && addr_i == ADDR_CTRL6) |=>
        recovered_clock_attenuator_bypass_o == $past(wdata_i[CTRL6_BYPASS_BIT]))
        else $error("bypass control not taken");
    a_pattern_rt: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (wr_st && wdata_i[BIT_PRBS]) |=> status_reg[BIT_PRBS] == $past(pattern_detect_i))
        else $error("pattern bit not real-time");
endmodule
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // =========================================
    // Bus cycles, released bus shows inverted values
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
    // Mask write, read, masked write-back
    task automatic poll(input logic [7:0] m);
        logic [7:0] d;
        write(8'h06, m);
        read(8'h06, d);
        write(8'h06, d & m);
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
    import liu_alarm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, e1 = 1'b1, lzs = 1'b0, strobe = 1'b0, pos = 1'b0;
    logic transmit_clock_in = 1'b0, transmit_clock_in_run = 1'b1, zeros = 1'b0, up_code = 1'b0, down_code = 1'b0;
    logic ones = 1'b0;
    logic cl = 1'b0, oc = 1'b0, pd = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr, wdata, rdata, rnd, scratch;
    logic       wr, rd, int_n, lost, byp;
    logic [2:0] sel;
    logic [7:0] exp_q[$];
    int         num_errors = 0, tests_run = 0, cnt = 0;
    host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
                     .wdata_o(wdata));
    liu_alarm_status_interrupt #(.T1_WIN(200)) dut (
        .clk_sys_i(clk), .reset_i(reset), .addr_i(addr), .wr_en_i(wr), .rd_en_i(rd),
        .wdata_i(wdata), .rdata_o(rdata), .int_n_o(int_n), .e1_mode_i(e1),
        .long_zero_count_select_i(lzs), .rx_bit_en_i(strobe), .receive_line_pos_i(pos),
        .receive_line_neg_i(1'b0), .transmit_clock_in_i(transmit_clock_in), .loop_up_match_i(up_code),
        .loop_down_match_i(down_code), .current_limit_hit_i(cl), .transmit_open_circuit_i(oc),
        .pattern_detect_i(pd), .transmit_clock_lost_o(lost),
        .recovered_clock_attenuator_bypass_o(byp), .error_count_select_o(sel));
    // =========================================
    // Clock, line bits every other cycle, transmit clock
    always #5 clk = ~clk;
    always @(posedge clk) begin
        #1;
        strobe = ~strobe;
        if (strobe) pos = ones ? 1'b1 : (zeros ? 1'b0 : ~pos);
        cnt++;
        if (transmit_clock_in_run && (cnt % 5 == 0)) transmit_clock_in = ~transmit_clock_in;
    end
    // =========================================
    // Checking
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Read data is valid one cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) check("read data", rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
        rd_seen <= rd;
    end
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.read(a, scratch);
    endtask
    task automatic poll(input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back(e);
        host.poll(m);
    endtask
    // Bounded wait for an interrupt level
    task automatic wait_int(input logic lvl);
        int i;
        for (i = 0; i < 8 && int_n !== lvl; i++) @(posedge clk);
        #1;
        check("int_n", {7'h00, int_n}, {7'h00, lvl});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    // =========================================
    // Scenarios
    initial begin
        rnd = 8'($urandom(32'h5CA1));
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        reg_rd(ADDR_STATUS, STATUS_RST);
        reg_rd(ADDR_MASK, MASK_RST);
        reg_rd(ADDR_CTRL6, CTRL6_RST);
        reg_rd(8'h3F, 8'h00);
        $display("test reset done");
        rnd = 8'($urandom());
        host.write(ADDR_CTRL6, rnd);
        reg_rd(ADDR_CTRL6, rnd);
        check("bypass", {7'h00, byp}, {7'h00, rnd[CTRL6_BYPASS_BIT]});
        check("select", {5'h00, sel}, {5'h00, rnd[2:0]});
        rnd = 8'($urandom());
        host.write(ADDR_MASK, rnd);
        reg_rd(ADDR_MASK, rnd);
        host.write(ADDR_MASK, 8'h00);
        $display("test control done");
        cl = 1'b1;
        oc = 1'b1;
        pd = 1'b1;
        repeat (4) @(posedge clk);
        poll(8'hFF, 8'h07);
        wait_int(1'b1);
        oc = 1'b0;
        pd = 1'b0;
        poll(8'hFF, 8'h04);
        cl = 1'b0;
        poll(8'h04, 8'h00);
        $display("test live bits done");
        host.write(ADDR_MASK, 8'h04);
        cl = 1'b1;
        wait_int(1'b0);
        poll(8'h04, 8'h04);
        wait_int(1'b1);
        cl = 1'b0;
        repeat (5) @(posedge clk);
        wait_int(1'b1);
        $display("test interrupt done");
        host.write(ADDR_MASK, 8'h20);
        transmit_clock_in_run = 1'b0;
        repeat (300) @(posedge clk);
        check("lost early", {7'h00, lost}, 8'h00);
        repeat (400) @(posedge clk);
        check("lost late", {7'h00, lost}, 8'h01);
        wait_int(1'b0);
        poll(8'hFF, 8'h20);
        wait_int(1'b1);
        transmit_clock_in_run = 1'b1;
        wait_int(1'b0);
        poll(8'h20, 8'h00);
        wait_int(1'b1);
        $display("test clock loss done");
        host.write(ADDR_MASK, 8'hC0);
        up_code = 1'b1;
        down_code = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        up_code = 1'b0;
        down_code = 1'b0;
        wait_int(1'b0);
        poll(8'hFF, 8'hC0);
        poll(8'hFF, 8'h00);
        wait_int(1'b1);
        host.write(ADDR_MASK, 8'h00);
        $display("test loop codes done");
        zeros = 1'b1;
        repeat (400) @(posedge clk);
        poll(8'hFF, 8'h00);
        repeat (200) @(posedge clk);
        poll(8'hFF, 8'h08);
        poll(8'hFF, 8'h08);
        zeros = 1'b0;
        ones = 1'b1;
        repeat (2200) @(posedge clk);
        poll(8'hFF, 8'h18);
        poll(8'hFF, 8'h10);
        e1 = 1'b0;
        ones = 1'b0;
        repeat (600) @(posedge clk);
        poll(8'hFF, 8'h10);
        poll(8'hFF, 8'h00);
        zeros = 1'b1;
        repeat (300) @(posedge clk);
        poll(8'hFF, 8'h00);
        repeat (200) @(posedge clk);
        poll(8'hFF, 8'h08);
        zeros = 1'b0;
        ones = 1'b1;
        repeat (500) @(posedge clk);
        poll(8'hFF, 8'h18);
        lzs = 1'b1;
        ones = 1'b0;
        zeros = 1'b1;
        repeat (1000) @(posedge clk);
        poll(8'hFF, 8'h10);
        repeat (2400) @(posedge clk);
        poll(8'hFF, 8'h08);
        $display("test carrier loss done");
        wrap_up();
    end
endmodule
`default_nettype wire
